/* verilog/mes_pkg.sv */
// Purpose: constants and types for the mac event status block
// Assumes: one 50 MHz system clock, synchronous active-high reset
// Notes:   register map over ahb-lite, one aligned word per register
//
// Operation
// [R01] tx bus error flag bit 24 on dma error response during transmit
// [R02] tx descriptor unavailable bit 23, dma halts until tx start demand
// [R03] late collision bit 22, half duplex, collision after 64-byte window
// [R04] tx abort bit 21 after 16 consecutive collisions, half duplex
// [R05] no carrier bit 20 when carrier sense missing during transmit, half
// [R06] defer exceeded bit 19 when no-defer clear, half duplex, long defer
// [R07] tx complete bit 18 on each correctly finished transmission
// [R08] tx underflow bit 17, packet retransmitted without software
// [R09] software should raise tx fifo threshold on frequent underflow
// [R10] tx summary bit 16 is or of enabled status bits 17 to 24
// [R11] tx interrupt only when tx summary and tx master enable are set
// [R12] tx summary not stored; clearing bits 17 to 24 drops it
// [R13] control frame bit 14 in full duplex, feeds rx summary when enabled
// [R14] rx bus error bit 11 on dma error; software should reset mac
// [R15] rx descriptor unavailable bit 10, dma halts until rx start demand
// [R16] early notice bit 9 once length/type field is received
// [R17] max length exceeded bit 8, oversized packet is dropped
// [R18] missed count overflow bit 7 when missed packet counter rolls over
// [R19] runt bit 6 for frames under 64 bytes unless accept-runt set
// [R20] alignment error bit 5 when frame length not whole bytes
// [R21] writing 1 clears a status flag, writing 0 leaves it alone
// [R22] each rx flag feeds rx summary only while its enable bit is set
// [R23] rx summary bit 0 is or of enabled status bits 1 to 14
// [R24] rx interrupt only when rx summary and rx master enable bit 0
// [R25] flags sticky until cleared; event wins over same-cycle clear
package mes_pkg;

    // ------
    // register map
    // ------
    localparam logic [7:0]  MES_EVENT_ENABLE_OFF = 8'h00;
    localparam logic [7:0]  MES_EVENT_STATUS_OFF = 8'h04;
    localparam logic [7:0]  MES_CONTROL_OFF      = 8'h08;
    localparam logic [7:0]  MES_DMA_HALT_OFF     = 8'h0C;
    localparam logic [31:0] MES_STATUS_RESET     = 32'h0000_0000;
    localparam logic [31:0] MES_ENABLE_RESET     = 32'h0000_0000;

    // ------
    // field positions
    // ------
    localparam int MES_TX_BUS_ERROR_BIT    = 24;
    localparam int MES_TX_DESC_UNAVAIL_BIT = 23;
    localparam int MES_LATE_COLLISION_BIT  = 22;
    localparam int MES_TX_ABORT_BIT        = 21;
    localparam int MES_NO_CARRIER_BIT      = 20;
    localparam int MES_DEFER_EXCEEDED_BIT  = 19;
    localparam int MES_TX_COMPLETE_BIT     = 18;
    localparam int MES_TX_UNDERFLOW_BIT    = 17;
    localparam int MES_TX_SUMMARY_BIT      = 16;
    localparam int MES_FLOW_CTRL_BIT       = 14;
    localparam int MES_RX_BUS_ERROR_BIT    = 11;
    localparam int MES_RX_DESC_UNAVAIL_BIT = 10;
    localparam int MES_EARLY_NOTICE_BIT    = 9;
    localparam int MES_MAX_LEN_BIT         = 8;
    localparam int MES_MISSED_OVF_BIT      = 7;
    localparam int MES_RUNT_BIT            = 6;
    localparam int MES_ALIGN_BIT           = 5;
    localparam int MES_RX_SUMMARY_BIT      = 0;
    // control register fields
    localparam int MES_CTRL_FULL_DUPLEX_BIT = 0;
    localparam int MES_CTRL_NO_DEFER_BIT    = 1;
    localparam int MES_CTRL_ACCEPT_RUNT_BIT = 2;
    localparam int MES_CTRL_SPEED_100_BIT   = 3;
    // dma halt register fields
    localparam int MES_HALT_TX_BIT = 0;
    localparam int MES_HALT_RX_BIT = 1;

    // status bits this block owns (tx 24..17, rx 14, 11..5)
    localparam logic [31:0] MES_TX_FLAG_MASK = 32'h01FE_0000;
    localparam logic [31:0] MES_RX_FLAG_MASK = 32'h0000_4FE0;
    // summary groups as documented: tx 24..17, rx 14..1
    localparam logic [31:0] MES_TX_GROUP     = 32'h01FE_0000;
    localparam logic [31:0] MES_RX_GROUP     = 32'h0000_7FFE;

    // ------
    // timing and frame figures
    // ------
    localparam int MES_CLK_MHZ             = 50;
    localparam int MES_DEFER_100_NS        = 327680; // 0.32768 ms
    localparam int MES_DEFER_10_NS         = 3276800; // 3.2768 ms
    localparam int MES_DEFER_100_CYC =
        (MES_DEFER_100_NS * MES_CLK_MHZ) / 1000;
    localparam int MES_DEFER_10_CYC =
        (MES_DEFER_10_NS * MES_CLK_MHZ) / 1000;
    localparam logic [4:0]  MES_MAX_COLLISIONS  = 5'd16;
    localparam logic [6:0]  MES_COLLISION_WINDOW = 7'd64;
    localparam logic [15:0] MES_MIN_FRAME_BYTES = 16'd64;

    // ------
    // event carriers
    // ------
    typedef struct packed {
        logic       dma_error;     // bus error on transmit dma
        logic       desc_empty;    // no transmit descriptor
        logic       collision;     // one collision pulse
        logic [6:0] bytes_sent;    // bytes sent so far, saturating
        logic       frame_start;   // first cycle of a transmission
        logic       in_frame;      // transmission in progress
        logic       frame_ok;      // transmission finished correctly
        logic       deferring;     // waiting frame held off by carrier
        logic       underflow;     // fifo ran dry during packet
    } mes_tx_event_type;

    typedef struct packed {
        logic        ctrl_frame;   // flow control frame received
        logic        dma_error;    // bus error on receive dma
        logic        desc_empty;   // no receive descriptor
        logic        len_type_done;// length/type field received
        logic        too_long;     // frame exceeded programmed maximum
        logic        miss_rollover;// missed packet counter wrapped
        logic        frame_end;    // end of a received frame
        logic [15:0] frame_bytes;  // byte count at frame end
        logic        odd_bits;     // trailing bits not a whole byte
    } mes_rx_event_type;

endpackage : mes_pkg

/* verilog/mes_event_status.sv */
// Purpose: mac event status and enable registers with summary interrupts
// Assumes: events come from logic on sys_clk_in except carrier sense pin
// Notes:   summaries are combinational; status bits 4..1 are held elsewhere
`timescale 1ns/1ps
`default_nettype none

module mes_event_status
    import mes_pkg::*;
#(
    parameter int DEFER_100_CYCLES = MES_DEFER_100_CYC,
    parameter int DEFER_10_CYCLES  = MES_DEFER_10_CYC
) (
    input  wire logic             sys_clk_in,
    input  wire logic             sys_rst_in,
    // ahb-lite slave
    input  wire logic             hsel_in,
    input  wire logic [31:0]      haddr_in,
    input  wire logic [1:0]       htrans_in,
    input  wire logic             hwrite_in,
    input  wire logic [2:0]       hsize_in,
    input  wire logic             hready_in,
    input  wire logic [31:0]      hwdata_in,
    output logic      [31:0]      hrdata_out,
    output logic                  hreadyout_out,
    output logic                  hresp_out,
    // event inputs
    input  wire mes_tx_event_type tx_event_in,
    input  wire mes_rx_event_type rx_event_in,
    input  wire logic             carrier_sense_in,
    input  wire logic             tx_start_demand_in,
    input  wire logic             rx_start_demand_in,
    // outputs
    output logic                  tx_irq_out,
    output logic                  rx_irq_out,
    output logic                  tx_dma_halt_out,
    output logic                  rx_dma_halt_out,
    output logic                  tx_abort_pulse_out,
    output logic                  tx_retry_out,
    output logic                  rx_drop_out
);

    // ------
    // ahb-lite address phase capture
    // ------
    logic        wr_pend_reg;
    logic        rd_pend_reg;
    logic [7:0]  addr_reg;
    logic        addr_valid;

    // single-cycle slave: zero wait states, always okay
    assign addr_valid = hsel_in && hready_in && htrans_in[1];
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
        end else begin
            wr_pend_reg <= addr_valid && hwrite_in;
            rd_pend_reg <= addr_valid && !hwrite_in;
            if (addr_valid) begin
                addr_reg <= haddr_in[7:0];
            end
        end
    end

    // write strobes, one per register except the read-only dma halt register, active in the data phase
    logic wr_enable;
    logic wr_status;
    logic wr_control;
    assign wr_enable  = wr_pend_reg && (addr_reg == MES_EVENT_ENABLE_OFF);
    assign wr_status  = wr_pend_reg && (addr_reg == MES_EVENT_STATUS_OFF);
    assign wr_control = wr_pend_reg && (addr_reg == MES_CONTROL_OFF);

    // ------
    // enable and control registers
    // ------
    logic [31:0] enable_reg;
    logic [3:0]  control_reg;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            enable_reg <= MES_ENABLE_RESET;
        end else if (wr_enable) begin
            enable_reg <= hwdata_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            control_reg <= 4'h0;
        end else if (wr_control) begin
            control_reg <= hwdata_in[3:0];
        end
    end

    logic full_duplex;
    logic half_duplex;
    assign full_duplex = control_reg[MES_CTRL_FULL_DUPLEX_BIT];
    assign half_duplex = !full_duplex;

    // ------
    // carrier sense synchroniser (pin input)
    // ------
    logic crs_meta_reg;
    logic crs_sync_reg;
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            crs_meta_reg <= 1'b0;
            crs_sync_reg <= 1'b0;
        end else begin
            crs_meta_reg <= carrier_sense_in;
            crs_sync_reg <= crs_meta_reg;
        end
    end

    // ------
    // collision counter, abort after sixteen in a row
    // ------
    logic [4:0] coll_cnt_reg;
    logic       abort_hit;
    assign abort_hit = half_duplex && tx_event_in.collision &&
                       (coll_cnt_reg == MES_MAX_COLLISIONS - 5'd1);
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || tx_event_in.frame_ok || abort_hit) begin
            coll_cnt_reg <= 5'd0;
        end else if (half_duplex && tx_event_in.collision) begin
            coll_cnt_reg <= coll_cnt_reg + 5'd1;
        end
    end

    // the abort pulse tells the transmitter to drop the packet
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            tx_abort_pulse_out <= 1'b0;
        end else begin
            tx_abort_pulse_out <= abort_hit; // R04
        end
    end

    // ------
    // deferral timer; counts long enough for the slow rate
    // ------
    logic [21:0] defer_cnt_reg;
    logic        defer_limit;
    logic        defer_fired_reg;
    assign defer_limit = control_reg[MES_CTRL_SPEED_100_BIT] ?
        (defer_cnt_reg >= 22'(DEFER_100_CYCLES)) :
        (defer_cnt_reg >= 22'(DEFER_10_CYCLES));
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || !tx_event_in.deferring) begin
            defer_cnt_reg   <= 22'd0;
            defer_fired_reg <= 1'b0;
        end else begin
            if (!defer_limit) begin
                defer_cnt_reg <= defer_cnt_reg + 22'd1;
            end
            // fire once per deferral, not every cycle past the limit
            if (defer_limit) begin
                defer_fired_reg <= 1'b1;
            end
        end
    end

    // ------
    // event decode
    // ------
    logic [31:0] ev;
    logic        runt_seen;
    assign runt_seen = rx_event_in.frame_end &&
                       (rx_event_in.frame_bytes < MES_MIN_FRAME_BYTES);
    always_comb begin
        ev = 32'h0000_0000;
        ev[MES_TX_BUS_ERROR_BIT]    = tx_event_in.dma_error; // R01
        ev[MES_TX_DESC_UNAVAIL_BIT] = tx_event_in.desc_empty; // R02
        ev[MES_LATE_COLLISION_BIT]  = half_duplex &&
            tx_event_in.collision &&
            (tx_event_in.bytes_sent >= MES_COLLISION_WINDOW); // R03
        ev[MES_TX_ABORT_BIT]        = abort_hit; // R04
        ev[MES_NO_CARRIER_BIT]      = half_duplex && !crs_sync_reg &&
            (tx_event_in.frame_start || tx_event_in.in_frame); // R05
        ev[MES_DEFER_EXCEEDED_BIT]  = half_duplex &&
            !control_reg[MES_CTRL_NO_DEFER_BIT] &&
            defer_limit && !defer_fired_reg; // R06
        ev[MES_TX_COMPLETE_BIT]     = tx_event_in.frame_ok; // R07
        ev[MES_TX_UNDERFLOW_BIT]    = tx_event_in.underflow; // R08
        ev[MES_FLOW_CTRL_BIT]       = full_duplex &&
            rx_event_in.ctrl_frame; // R13
        ev[MES_RX_BUS_ERROR_BIT]    = rx_event_in.dma_error; // R14
        ev[MES_RX_DESC_UNAVAIL_BIT] = rx_event_in.desc_empty; // R15
        ev[MES_EARLY_NOTICE_BIT]    = rx_event_in.len_type_done; // R16
        ev[MES_MAX_LEN_BIT]         = rx_event_in.too_long; // R17
        ev[MES_MISSED_OVF_BIT]      = rx_event_in.miss_rollover; // R18
        ev[MES_RUNT_BIT]            = runt_seen &&
            !control_reg[MES_CTRL_ACCEPT_RUNT_BIT]; // R19
        ev[MES_ALIGN_BIT]           = rx_event_in.frame_end &&
            rx_event_in.odd_bits; // R20
    end

    // underflow retransmits in hardware; no software step needed
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            tx_retry_out <= 1'b0;
        end else begin
            tx_retry_out <= tx_event_in.underflow; // R08
        end
    end

    // oversized or runt frames are discarded by the receiver
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            rx_drop_out <= 1'b0;
        end else begin
            rx_drop_out <= ev[MES_MAX_LEN_BIT] || ev[MES_RUNT_BIT]; // R17 R19
        end
    end

    // ------
    // sticky status flags, write one to clear, set beats clear
    // ------
    logic [31:0] status_reg;
    logic [31:0] status_next;
    logic [31:0] clr_mask;
    assign clr_mask = wr_status ? hwdata_in : 32'h0000_0000;
    always_comb begin
        status_next = ((status_reg & ~clr_mask) | ev) &
                      (MES_TX_FLAG_MASK | MES_RX_FLAG_MASK); // R21 R25
    end
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            status_reg <= MES_STATUS_RESET;
        end else begin
            status_reg <= status_next; // R25
        end
    end

    // ------
    // dma halt on missing descriptor, released by start demand
    // ------
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            tx_dma_halt_out <= 1'b0;
        end else if (tx_event_in.desc_empty) begin
            tx_dma_halt_out <= 1'b1; // R02
        end else if (tx_start_demand_in) begin
            tx_dma_halt_out <= 1'b0; // R02
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            rx_dma_halt_out <= 1'b0;
        end else if (rx_event_in.desc_empty) begin
            rx_dma_halt_out <= 1'b1; // R15
        end else if (rx_start_demand_in) begin
            rx_dma_halt_out <= 1'b0; // R15
        end
    end

    // ------
    // summaries: pure logic, never stored, so clearing flags drops them
    // ------
    logic tx_summary;
    logic rx_summary;
    assign tx_summary = |(status_reg & enable_reg & MES_TX_GROUP); // R10 R12
    assign rx_summary = |(status_reg & enable_reg & MES_RX_GROUP); // R22 R23
    assign tx_irq_out = tx_summary &&
        enable_reg[MES_TX_SUMMARY_BIT]; // R11
    assign rx_irq_out = rx_summary &&
        enable_reg[MES_RX_SUMMARY_BIT]; // R24

    // ------
    // read data, registered at the end of the address phase
    // ------
    logic [31:0] status_view;
    always_comb begin
        status_view = status_reg;
        status_view[MES_TX_SUMMARY_BIT] = tx_summary; // R10
        status_view[MES_RX_SUMMARY_BIT] = rx_summary; // R23
    end

    logic [31:0] rd_mux;
    always_comb begin
        case (haddr_in[7:0])
            MES_EVENT_ENABLE_OFF: rd_mux = enable_reg;
            MES_EVENT_STATUS_OFF: rd_mux = status_view;
            MES_CONTROL_OFF:      rd_mux = {28'h0, control_reg};
            MES_DMA_HALT_OFF:     rd_mux = {30'h0, rx_dma_halt_out,
                                            tx_dma_halt_out};
            default:              rd_mux = 32'h0000_0000;
        endcase
    end

    // data is latched at the address phase so it stands in the data phase
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (addr_valid && !hwrite_in) begin
            hrdata_out <= rd_mux;
        end
    end

endmodule : mes_event_status

`default_nettype wire

/* testbench/mes_event_status_sva.sv */
// Purpose: port checker for the mac event status block
// Assumes: one clock domain, bound to the design top module
// Notes:   pulse outputs are tied to their cause one cycle earlier
`timescale 1ns/1ps
`default_nettype none

module mes_event_status_sva
    import mes_pkg::*;
(
    input wire logic             sys_clk_in,
    input wire logic             sys_rst_in,
    input wire logic             hreadyout_out,
    input wire logic             hresp_out,
    input wire mes_tx_event_type tx_event_in,
    input wire mes_rx_event_type rx_event_in,
    input wire logic             tx_start_demand_in,
    input wire logic             tx_dma_halt_out,
    input wire logic             rx_dma_halt_out,
    input wire logic             tx_abort_pulse_out,
    input wire logic             tx_retry_out,
    input wire logic             rx_drop_out
);
    // ------
    // properties
    // ------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    AST_BUS_OKAY: assert property (hreadyout_out && !hresp_out)
        else $error("bus slave stalled or answered with an error");
    AST_ABORT_CAUSE: assert property
        (tx_abort_pulse_out |-> $past(tx_event_in.collision))
        else $error("abort pulse without a collision before it");
    AST_RETRY: assert property (tx_event_in.underflow |=> tx_retry_out)
        else $error("underflow not followed by a retry pulse");
    AST_RETRY_CAUSE: assert property
        (tx_retry_out |-> $past(tx_event_in.underflow))
        else $error("retry pulse without an underflow");
    AST_DROP_LONG: assert property
        (rx_event_in.too_long |=> rx_drop_out)
        else $error("oversized frame not dropped");
    AST_DROP_CAUSE: assert property
        (rx_drop_out |-> $past(rx_event_in.too_long | rx_event_in.frame_end))
        else $error("drop pulse without a frame event");
    AST_TX_HALT: assert property
        (tx_event_in.desc_empty |=> tx_dma_halt_out ##1
         (tx_dma_halt_out || $past(tx_start_demand_in)))
        else $error("tx dma not halted on missing descriptor");
    AST_TX_RELEASE: assert property
        (tx_dma_halt_out && tx_start_demand_in && !tx_event_in.desc_empty
         |=> !tx_dma_halt_out)
        else $error("tx start demand did not release the halt");
    AST_RX_HALT: assert property
        (rx_event_in.desc_empty |=> rx_dma_halt_out)
        else $error("rx dma not halted on missing descriptor");

    cover property (tx_abort_pulse_out);
    cover property (tx_dma_halt_out ##1 !tx_dma_halt_out);
    cover property (rx_drop_out);
endmodule : mes_event_status_sva

bind mes_event_status mes_event_status_sva u_sva (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .tx_event_in(tx_event_in), .rx_event_in(rx_event_in),
    .tx_start_demand_in(tx_start_demand_in),
    .tx_dma_halt_out(tx_dma_halt_out), .rx_dma_halt_out(rx_dma_halt_out),
    .tx_abort_pulse_out(tx_abort_pulse_out),
    .tx_retry_out(tx_retry_out), .rx_drop_out(rx_drop_out));

`default_nettype wire

/* testbench/mes_phy_model.sv */
// Purpose: media side model giving the carrier sense pin
// Assumes: carrier is present unless the bench asks for it to drop
// Notes:   registered so the pin never moves on the sampling edge
`timescale 1ns/1ps
`default_nettype none

module mes_phy_model (
    input  wire logic sys_clk_in,
    input  wire logic drop_carrier_in,
    output logic      carrier_sense_out
);
    // medium busy while our own frame goes out, lost only on command
    always_ff @(posedge sys_clk_in) begin
        carrier_sense_out <= !drop_carrier_in;
    end
endmodule : mes_phy_model

`default_nettype wire

/* testbench/mes_event_status_tb.sv */
// Purpose: self-checking bench for the mac event status block
// Assumes: single-word ahb-lite transfers, defer limits shortened
// Notes:   expectations come from the bench's own status function
`timescale 1ns/1ps
`default_nettype none

module mes_event_status_tb;
    import mes_pkg::*;

    // ------
    // signals and helpers
    // ------
    logic             clk = 1'b0;
    logic             rst, hsel, hwrite, tx_sd, rx_sd, lose, carrier;
    logic             tx_irq, rx_irq;
    logic [1:0]       htrans;
    logic [2:0]       hsize;
    logic [31:0]      haddr, hwdata, hrdata, rd, en, r, seed, ex;
    wire logic        hready;
    mes_tx_event_type tx_ev;
    mes_rx_event_type rx_ev;
    int               fails, check_count, cyc;
    int               tx_bits[8] = '{24, 23, 18, 21, 22, 20, 19, 17};
    localparam logic [7:0] STAT_ADDR = MES_EVENT_STATUS_OFF;

    always #10 clk = ~clk;

    function automatic logic [31:0] rnd_next(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : rnd_next

    // status readback: flags plus the two live summaries
    function automatic logic [31:0] exp_stat(input logic [31:0] f, e);
        return f | {15'h0, |(f & e & MES_TX_GROUP), 15'h0,
                    |(f & e & MES_RX_GROUP)};
    endfunction : exp_stat

    task automatic chk(input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report;
        if (fails == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report

    // race raises an rx event in the data phase of the transfer
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, input logic race);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
        if (race) rx_ev.miss_rollover <= 1'b1;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        if (race) rx_ev.miss_rollover <= 1'b0;
    endtask : xfer

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, 1'b0);
        chk(rd, exp);
    endtask : rdchk

    task automatic fire_tx(input int b);
        case (b)
            24: tx_ev.dma_error <= 1'b1;
            23: tx_ev.desc_empty <= 1'b1;
            18: tx_ev.frame_ok <= 1'b1;
            17: tx_ev.underflow <= 1'b1;
            22: begin tx_ev.collision <= 1'b1; tx_ev.bytes_sent <= 7'd64; end
            21: for (int i = 0; i < 16; i++) begin
                tx_ev.collision <= 1'b1;
                @(posedge clk);
                tx_ev.collision <= 1'b0;
                @(posedge clk);
            end
            // carrier drop passes the partner flop and a two-flop sync
            20: begin lose <= 1'b1; repeat (4) @(posedge clk);
                tx_ev.frame_start <= 1'b1; end
            19: begin tx_ev.deferring <= 1'b1; repeat (25) @(posedge clk); end
            default: ;
        endcase
        @(posedge clk);
        tx_ev <= '0;
        lose  <= 1'b0;
        @(posedge clk);
    endtask : fire_tx

    task automatic fire_rx(input logic [31:0] f, input logic [15:0] n);
        rx_ev.ctrl_frame <= f[14]; rx_ev.dma_error <= f[11];
        rx_ev.desc_empty <= f[10]; rx_ev.len_type_done <= f[9];
        rx_ev.too_long <= f[8]; rx_ev.miss_rollover <= f[7];
        rx_ev.frame_end <= f[6] | f[5]; rx_ev.frame_bytes <= n;
        rx_ev.odd_bits <= f[5];
        @(posedge clk);
        rx_ev <= '0;
        @(posedge clk);
    endtask : fire_rx

    mes_phy_model u_phy (.sys_clk_in(clk), .drop_carrier_in(lose),
        .carrier_sense_out(carrier));

    mes_event_status #(.DEFER_100_CYCLES(8), .DEFER_10_CYCLES(20)) dut (
        .sys_clk_in(clk), .sys_rst_in(rst), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(hsize), .hready_in(hready), .hwdata_in(hwdata),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(),
        .tx_event_in(tx_ev), .rx_event_in(rx_ev),
        .carrier_sense_in(carrier), .tx_start_demand_in(tx_sd),
        .rx_start_demand_in(rx_sd), .tx_irq_out(tx_irq),
        .rx_irq_out(rx_irq), .tx_dma_halt_out(), .rx_dma_halt_out(),
        .tx_abort_pulse_out(), .tx_retry_out(), .rx_drop_out());

    // a hang costs one mismatch and ends the run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin fails++; final_report(); end
    end

    // ------
    // main sequence
    // ------
    initial begin
        rst = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'b010; hwdata = '0; tx_ev = '0; rx_ev = '0; tx_sd = 1'b0;
        rx_sd = 1'b0; lose = 1'b0; seed = 32'h8105; fails = 0;
        check_count = 0; cyc = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdchk(MES_EVENT_ENABLE_OFF, MES_ENABLE_RESET);
        rdchk(MES_EVENT_STATUS_OFF, MES_STATUS_RESET);
        rdchk(MES_CONTROL_OFF, 32'h0);
        xfer(1'b1, 8'h10, 32'hFFFF_FFFF, 1'b0);
        rdchk(8'h10, 32'h0);
        // each tx flag alone, random enables, then write-0 and write-1
        foreach (tx_bits[i]) begin
            seed = rnd_next(seed);
            en = (seed & 32'h01FF_0000) | (32'h1 << tx_bits[i]);
            r = 32'h1 << tx_bits[i];
            xfer(1'b1, MES_EVENT_ENABLE_OFF, en, 1'b0);
            fire_tx(tx_bits[i]);
            ex = exp_stat(r, en);
            rdchk(STAT_ADDR, ex);
            chk({31'h0, tx_irq}, {31'h0, en[16]});
            xfer(1'b1, STAT_ADDR, ~r, 1'b0);
            rdchk(STAT_ADDR, ex);
            xfer(1'b1, STAT_ADDR, r, 1'b0);
            rdchk(STAT_ADDR, 32'h0);
            chk({31'h0, tx_irq}, 32'h0);
        end
        rdchk(MES_DMA_HALT_OFF, 32'h1);
        tx_sd <= 1'b1;
        @(posedge clk);
        tx_sd <= 1'b0;
        rdchk(MES_DMA_HALT_OFF, 32'h0);
        // rx flags in random groups under full duplex
        xfer(1'b1, MES_CONTROL_OFF, 32'h1, 1'b0);
        for (int k = 0; k < 6; k++) begin
            seed = rnd_next(seed);
            en = seed;
            seed = rnd_next(seed);
            r = (k == 0) ? MES_RX_FLAG_MASK : (seed & MES_RX_FLAG_MASK);
            xfer(1'b1, MES_EVENT_ENABLE_OFF, en, 1'b0);
            fire_rx(r, r[6] ? 16'd63 : 16'd64);
            ex = exp_stat(r, en);
            rdchk(STAT_ADDR, ex);
            chk({31'h0, rx_irq}, {31'h0, ex[0] & en[0]});
            rdchk(MES_DMA_HALT_OFF, {30'h0, r[10], 1'b0});
            rx_sd <= 1'b1;
            @(posedge clk);
            rx_sd <= 1'b0;
            rdchk(MES_DMA_HALT_OFF, 32'h0);
            xfer(1'b1, STAT_ADDR, 32'hFFFF_FFFF, 1'b0);
            rdchk(STAT_ADDR, 32'h0);
        end
        // short frame kept when runts are accepted
        xfer(1'b1, MES_CONTROL_OFF, 32'h5, 1'b0);
        fire_rx(32'h40, 16'd10);
        rdchk(STAT_ADDR, 32'h0);
        // new event in the same cycle as its clear keeps the flag
        fire_rx(32'h80, 16'd64);
        xfer(1'b1, STAT_ADDR, 32'h80, 1'b1);
        rdchk(STAT_ADDR, exp_stat(32'h80, en));
        // duplex gating, no-defer, and the fast-rate defer limit
        xfer(1'b1, STAT_ADDR, 32'hFFFF_FFFF, 1'b0);
        fire_tx(22);
        fire_tx(20);
        xfer(1'b1, MES_CONTROL_OFF, 32'h2, 1'b0);
        fire_tx(19);
        xfer(1'b1, MES_CONTROL_OFF, 32'h8, 1'b0);
        fire_rx(32'h4000, 16'd64);
        fire_tx(19);
        rdchk(STAT_ADDR, exp_stat(32'h0008_0000, en));
        final_report();
    end
endmodule : mes_event_status_tb

`default_nettype wire
